// file: spp_port.sv
// six pin bidirectional port with level change and external interrupt
// Overview of operation
// R1 - six pins behind one data register
// R2 - per-pin direction bit selects input/output
// R3 - per-pin pull-high enable for inputs
// R4 - pull-low only pins 0-3, bits 7:4
// R5 - per-pin open-drain select for outputs
// R6 - selected pin change sets port change flag
// R7 - irq when flag, enable and global set
// R8 - external irq select makes pin 0 input
// R9 - external irq disables pin 0 change detect
// R10 - ir enable drives carrier onto pin 1
// R11 - pin 3 low resets when selected
// R12 - clock out pin 4 in normal/standby
// R13 - pin 2 feeds timer external clocks
// R14 - pin 2 outputs pulse or beeper
// R15 - per-pin read of pad or latch
// R16 - edge select for external interrupt
// R17 - carrier polarity gated by output data
// R18 - compare samples; flag cleared by writing zero
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`include "spp_consts.svh"

module spp_port
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pads
  input wire logic [5:0] pad_in,
  output logic [5:0] pad_out,
  output logic [5:0] pad_oe,
  output logic [5:0] pull_high_en,
  output logic [5:0] pull_low_en,
  // alternate function sources
  input wire logic ir_carrier_data,
  input wire logic pulse_data,
  input wire logic beeper_data,
  input wire logic inst_clk_level,
  input wire logic [1:0] op_mode,
  // alternate function sinks
  output logic ext_count_clock_in_a,
  output logic ext_count_clock_in_b,
  output logic ext_irq_signal,
  output logic ext_reset_req,
  output logic port_irq_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // software visible storage, all cleared or preset by rst
  logic [5:0] port_data_ff; // output data latch
  logic [5:0] port_direction_ff; // 1 = input
  logic [5:0] pull_high_ctrl_ff; // 1 = pull-high on
  logic [7:0] pull_low_ctrl_ff; // bits 7:4 used
  logic [5:0] open_drain_ctrl_ff; // 1 = open drain
  logic [5:0] level_change_select_ff; // monitored pins
  logic [7:0] irq_flag_ff; // flag register
  logic [7:0] irq_enable_ff; // enable register
  logic [7:0] power_ctrl_one_ff; // global enable at bit 7
  logic [7:0] power_ctrl_ff; // ext select at bit 6
  logic [7:0] ir_ctrl_ff; // carrier control
  logic [5:0] read_src_ff; // 1 = read latch
  logic [7:0] func_ctrl_ff; // configuration word and timer selects
  logic [7:0] tmr_b_ctrl_one_ff; // pulse enable at bit 7
  logic [7:0] beeper_ctrl_ff; // beeper enable at bit 7
  logic [1:0] evt_status_ff; // sticky events
  logic [1:0] evt_mask_ff; // event mask
  logic [5:0] prev_pad_ff; // previous pad sample
  logic [7:0] rdata_ff; // read data
  // ----------------------------------------------------------------
  // output flip-flops: every port of the block except reg_rdata (from rdata_ff) comes from one of these
  // ----------------------------------------------------------------
  // pad drive level, registered so the pad never sees decode glitches
  logic [5:0] pad_out_ff;
  // pad drive enable, high while the port drives the pin
  logic [5:0] pad_oe_ff;
  // pull-high enables as seen by the pad cells
  logic [5:0] ph_ff;
  // pull-low enables, the top two bits stay low
  logic [5:0] pl_ff;
  // timer a external clock level
  logic ta_ff;
  // timer b external clock level
  logic tb_ff;
  // one-cycle external interrupt pulse
  logic ext_sig_ff;
  // reset request from the pin 3 reset function
  logic rst_req_ff;
  // port change interrupt request
  logic pirq_ff;
  // summary event interrupt
  logic irq_ff;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // one strobe per register; an unmapped address matches none of them,
  // so a write there is dropped and a read there returns zero
  wire wr_data = reg_wr && reg_addr == `SPP_OFS_DATA;
  wire wr_dir = reg_wr && reg_addr == `SPP_OFS_DIR;
  wire wr_ph = reg_wr && reg_addr == `SPP_OFS_PULL_HIGH;
  wire wr_pl = reg_wr && reg_addr == `SPP_OFS_PULL_LOW;
  wire wr_od = reg_wr && reg_addr == `SPP_OFS_OPEN_DRAIN;
  wire wr_cs = reg_wr && reg_addr == `SPP_OFS_CHANGE_SEL;
  wire wr_flag = reg_wr && reg_addr == `SPP_OFS_IRQ_FLAG;
  wire wr_ien = reg_wr && reg_addr == `SPP_OFS_IRQ_ENABLE;
  wire wr_p1 = reg_wr && reg_addr == `SPP_OFS_POWER_ONE;
  wire wr_p0 = reg_wr && reg_addr == `SPP_OFS_POWER;
  wire wr_ir = reg_wr && reg_addr == `SPP_OFS_IR_CTRL;
  wire wr_rs = reg_wr && reg_addr == `SPP_OFS_READ_SRC;
  wire wr_fc = reg_wr && reg_addr == `SPP_OFS_FUNC_CTRL;
  wire wr_mask = reg_wr && reg_addr == `SPP_OFS_EVT_MASK;
  wire rd_evt = reg_rd && reg_addr == `SPP_OFS_EVT_STATUS;

  // timer b and beeper control words sit at their own offsets above the
  // event mask; only their enable bits reach the pad logic
  wire wr_tb = reg_wr && reg_addr == `SPP_OFS_TMR_B_CTRL;
  wire wr_bz = reg_wr && reg_addr == `SPP_OFS_BEEPER_CTRL;
  wire pulse_out_enable = tmr_b_ctrl_one_ff[`SPP_BIT_PULSE_OUT];
  wire beeper_enable = beeper_ctrl_ff[`SPP_BIT_BEEPER];

  // ----------------------------------------------------------------
  // alternate function selection
  // ----------------------------------------------------------------
  // each function but the timer clocks takes its pin over from the general purpose path;
  // pulse and beeper share pin 2, and the configuration bit decides
  // which of the two enables and levels reaches the pad
  wire ext_irq_select = power_ctrl_ff[`SPP_BIT_EXT_IRQ_SEL];
  wire ir_carrier_enable = ir_ctrl_ff[`SPP_BIT_IR_EN];
  wire carrier_polarity_select = ir_ctrl_ff[`SPP_BIT_IR_POL];
  wire cfg_ext_reset = func_ctrl_ff[`SPP_FC_EXT_RESET];
  wire cfg_clk_out = func_ctrl_ff[`SPP_FC_CLK_OUT];
  wire cfg_pb2_pwm = func_ctrl_ff[`SPP_FC_PB2_PWM];
  wire ext_irq_edge_select = func_ctrl_ff[`SPP_FC_EDGE_FALL];
  wire tmr_a_clock_select = func_ctrl_ff[`SPP_FC_TA_CLK];
  wire tmr_a_low_clock_select = func_ctrl_ff[`SPP_FC_TA_LOW];
  wire tmr_b_clock_select = func_ctrl_ff[`SPP_FC_TB_CLK];
  // R17 carrier gating polarity
  wire ir_gate = carrier_polarity_select ? ~port_data_ff[1] : port_data_ff[1];
  // R10 carrier on pin 1
  wire ir_drive = ir_carrier_enable;
  wire ir_level = ir_gate & ir_carrier_data;
  // R14 pulse or beeper on pin 2
  wire pulse_beeper_enable = cfg_pb2_pwm ? pulse_out_enable : beeper_enable;
  wire pulse_beeper_data = cfg_pb2_pwm ? pulse_data : beeper_data;
  // R12 clock out while normal or standby
  wire clk_out_on = cfg_clk_out && (op_mode == spp_pkg::SPP_MODE_NORMAL ||
                                    op_mode == spp_pkg::SPP_MODE_STANDBY);

  // pins 0, 3 and 5 have no output function; pins 0 and 3 may instead
  // be claimed as inputs by the interrupt and reset functions
  // per-pin forced output and level
  wire [5:0] force_out = {1'b0, clk_out_on, 1'b0, pulse_beeper_enable, ir_drive, 1'b0};
  wire [5:0] alt_level = {1'b0, inst_clk_level, 1'b0, pulse_beeper_data, ir_level, 1'b0};
  // R8 pin 0 forced input by external select; R11 pin 3 input as reset
  wire [5:0] force_in = {2'b00, cfg_ext_reset, 2'b00, ext_irq_select};

  logic [5:0] nxt_pad_out;
  logic [5:0] nxt_pad_oe;
  logic [5:0] nxt_ph;
  logic [5:0] nxt_pl;
  logic [5:0] pin_rd;

  // ----------------------------------------------------------------
  // per-pin pad logic
  // ----------------------------------------------------------------
  // forced inputs beat forced outputs and the direction bit, so a pin
  // claimed as an interrupt or reset input never fights the board;
  // open drain also applies to function outputs, which then only pull
  // low and rely on the board for the high level
  // pins 0 to 3 get a pull-low leg, pins 4 and 5 a constant zero
  genvar gi;
  generate
    for (gi = 0; gi < `SPP_NPINS; gi = gi + 1)
    begin : g_pin
      // R2 direction with function overrides
      wire is_out = (force_out[gi] | ~port_direction_ff[gi]) & ~force_in[gi];
      wire lvl = force_out[gi] ? alt_level[gi] : port_data_ff[gi];
      // R5 open drain drives only low
      assign nxt_pad_oe[gi] = is_out & (~open_drain_ctrl_ff[gi] | ~lvl);
      assign nxt_pad_out[gi] = lvl;
      // R3 pull-high on inputs
      assign nxt_ph[gi] = ~is_out & pull_high_ctrl_ff[gi];
      // R4 pull-low exists on pins 0-3 only
      if (gi < 4)
      begin : g_pl
        assign nxt_pl[gi] = ~is_out & pull_low_ctrl_ff[`SPP_PULL_LOW_LSB + gi];
      end
      else
      begin : g_nopl
        assign nxt_pl[gi] = 1'b0;
      end
      // R15 read pad or latch
      assign pin_rd[gi] = read_src_ff[gi] ? port_data_ff[gi] : pad_in[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // change and external interrupt detection
  // ----------------------------------------------------------------
  // prev_pad_ff follows the pads every cycle whether or not a pin is
  // watched, so turning the watch on later never reports a stale change
  // R9 pin 0 change disabled under external irq
  wire [5:0] watch = level_change_select_ff & {5'h1F, ~ext_irq_select};
  // R18 compare with previous sample
  wire set_port_change_flag = |((pad_in ^ prev_pad_ff) & watch);
  // R16 edge select: 1 = falling
  wire ext_edge = ext_irq_edge_select ? (prev_pad_ff[0] & ~pad_in[0])
                                      : (~prev_pad_ff[0] & pad_in[0]);
  wire ext_evt = ext_irq_select & ext_edge;
  // R7 request gating
  wire nxt_pirq = irq_flag_ff[`SPP_BIT_PORT_CHANGE] & irq_enable_ff[`SPP_BIT_PORT_CHANGE]
                  & power_ctrl_one_ff[`SPP_BIT_GLOBAL_IRQ];

  // read mux, registered below only when a read strobe is present so
  // that the read data stay zero outside the answer cycle
  logic [7:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      `SPP_OFS_DATA: rd_mux = {2'b00, pin_rd};
      `SPP_OFS_DIR: rd_mux = {2'b00, port_direction_ff};
      `SPP_OFS_PULL_HIGH: rd_mux = {2'b00, pull_high_ctrl_ff};
      `SPP_OFS_PULL_LOW: rd_mux = {pull_low_ctrl_ff[7:4], 4'h0};
      `SPP_OFS_OPEN_DRAIN: rd_mux = {2'b00, open_drain_ctrl_ff};
      `SPP_OFS_CHANGE_SEL: rd_mux = {2'b00, level_change_select_ff};
      `SPP_OFS_IRQ_FLAG: rd_mux = irq_flag_ff;
      `SPP_OFS_IRQ_ENABLE: rd_mux = irq_enable_ff;
      `SPP_OFS_POWER_ONE: rd_mux = power_ctrl_one_ff;
      `SPP_OFS_POWER: rd_mux = power_ctrl_ff;
      `SPP_OFS_IR_CTRL: rd_mux = ir_ctrl_ff;
      `SPP_OFS_READ_SRC: rd_mux = {2'b00, read_src_ff};
      `SPP_OFS_FUNC_CTRL: rd_mux = func_ctrl_ff;
      `SPP_OFS_EVT_STATUS: rd_mux = {6'h00, evt_status_ff};
      `SPP_OFS_EVT_MASK: rd_mux = {6'h00, evt_mask_ff};
      // upper offsets hold timer b and beeper enables
      `SPP_OFS_TMR_B_CTRL: rd_mux = tmr_b_ctrl_one_ff;
      `SPP_OFS_BEEPER_CTRL: rd_mux = beeper_ctrl_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // storage that changes only when addressed; the pull-low register keeps
  // its low nibble at zero since no bit there controls a pin
  // R1 data and configuration writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      port_data_ff <= 6'h00;
      port_direction_ff <= `SPP_RST_DIR;
      pull_high_ctrl_ff <= 6'h00;
      pull_low_ctrl_ff <= `SPP_RST_BYTE;
      open_drain_ctrl_ff <= 6'h00;
      level_change_select_ff <= 6'h00;
      irq_enable_ff <= `SPP_RST_BYTE;
      power_ctrl_one_ff <= `SPP_RST_BYTE;
      power_ctrl_ff <= `SPP_RST_BYTE;
      ir_ctrl_ff <= `SPP_RST_BYTE;
      read_src_ff <= 6'h00;
      func_ctrl_ff <= `SPP_RST_BYTE;
      tmr_b_ctrl_one_ff <= `SPP_RST_BYTE;
      beeper_ctrl_ff <= `SPP_RST_BYTE;
      evt_mask_ff <= 2'b00;
    end
    else
    begin
      if (wr_data) port_data_ff <= reg_wdata[5:0];
      if (wr_dir) port_direction_ff <= reg_wdata[5:0];
      if (wr_ph) pull_high_ctrl_ff <= reg_wdata[5:0];
      if (wr_pl) pull_low_ctrl_ff <= {reg_wdata[7:4], 4'h0};
      if (wr_od) open_drain_ctrl_ff <= reg_wdata[5:0];
      if (wr_cs) level_change_select_ff <= reg_wdata[5:0];
      if (wr_ien) irq_enable_ff <= reg_wdata;
      if (wr_p1) power_ctrl_one_ff <= reg_wdata;
      if (wr_p0) power_ctrl_ff <= reg_wdata;
      if (wr_ir) ir_ctrl_ff <= reg_wdata;
      if (wr_rs) read_src_ff <= reg_wdata[5:0];
      if (wr_fc) func_ctrl_ff <= reg_wdata;
      if (wr_tb) tmr_b_ctrl_one_ff <= reg_wdata;
      if (wr_bz) beeper_ctrl_ff <= reg_wdata;
      if (wr_mask) evt_mask_ff <= reg_wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // flags, events and outputs
  // ----------------------------------------------------------------
  // a change seen in the same cycle as a clearing write or a status read
  // survives it, so no event is lost to a race with software
  // R6 set wins over software clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_flag_ff <= `SPP_RST_BYTE;
      evt_status_ff <= 2'b00;
      prev_pad_ff <= 6'h00;
    end
    else
    begin
      // R18 cleared only by writing zero
      irq_flag_ff <= (wr_flag ? (irq_flag_ff & reg_wdata) : irq_flag_ff)
                     | {6'h00, set_port_change_flag, 1'b0};
      evt_status_ff <= (rd_evt ? 2'b00 : evt_status_ff) | {ext_evt, set_port_change_flag};
      prev_pad_ff <= pad_in;
    end
  end

  // registered outputs: everything leaving the block is one cycle behind
  // its decode, which keeps the pad and interrupt timing fixed
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_ff <= 8'h00;
      pad_out_ff <= 6'h00;
      pad_oe_ff <= 6'h00;
      ph_ff <= 6'h00;
      pl_ff <= 6'h00;
      ta_ff <= 1'b0;
      tb_ff <= 1'b0;
      ext_sig_ff <= 1'b0;
      rst_req_ff <= 1'b0;
      pirq_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
      pad_out_ff <= nxt_pad_out;
      pad_oe_ff <= nxt_pad_oe;
      ph_ff <= nxt_ph;
      pl_ff <= nxt_pl;
      // timer inputs are plain levels; the timers pick their own edge
      // R13 timer external clocks from pin 2
      ta_ff <= tmr_a_clock_select & ~tmr_a_low_clock_select & pad_in[2];
      tb_ff <= tmr_b_clock_select & pad_in[2];
      // one edge per pin change, so the pulse never lasts two cycles
      ext_sig_ff <= ext_evt;
      // R11 active-low reset on pin 3
      rst_req_ff <= cfg_ext_reset & ~pad_in[3];
      pirq_ff <= nxt_pirq;
      irq_ff <= |(evt_status_ff & evt_mask_ff);
    end
  end

  assign reg_rdata = rdata_ff;
  assign pad_out = pad_out_ff;
  assign pad_oe = pad_oe_ff;
  assign pull_high_en = ph_ff;
  assign pull_low_en = pl_ff;
  assign ext_count_clock_in_a = ta_ff;
  assign ext_count_clock_in_b = tb_ff;
  assign ext_irq_signal = ext_sig_ff;
  assign ext_reset_req = rst_req_ff;
  assign port_irq_req = pirq_ff;
  assign irq = irq_ff;

endmodule

// file: spp_consts.svh
// constants of the six pin port: register offsets, field positions, reset values
`ifndef SPP_CONSTS_SVH
`define SPP_CONSTS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses of 32-bit words)
// ----------------------------------------------------------------
`define SPP_OFS_DATA 8'h00
`define SPP_OFS_DIR 8'h04
`define SPP_OFS_PULL_HIGH 8'h08
`define SPP_OFS_PULL_LOW 8'h0C
`define SPP_OFS_OPEN_DRAIN 8'h10
`define SPP_OFS_CHANGE_SEL 8'h14
`define SPP_OFS_IRQ_FLAG 8'h18
`define SPP_OFS_IRQ_ENABLE 8'h1C
`define SPP_OFS_POWER_ONE 8'h20
`define SPP_OFS_POWER 8'h24
`define SPP_OFS_IR_CTRL 8'h28
`define SPP_OFS_READ_SRC 8'h2C
`define SPP_OFS_FUNC_CTRL 8'h30
`define SPP_OFS_EVT_STATUS 8'h34
`define SPP_OFS_EVT_MASK 8'h38
`define SPP_OFS_TMR_B_CTRL 8'h3C
`define SPP_OFS_BEEPER_CTRL 8'h40
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPP_BIT_PORT_CHANGE 1
`define SPP_BIT_GLOBAL_IRQ 7
`define SPP_BIT_EXT_IRQ_SEL 6
`define SPP_BIT_IR_EN 0
`define SPP_BIT_IR_POL 2
`define SPP_PULL_LOW_LSB 4
`define SPP_BIT_PULSE_OUT 7
`define SPP_BIT_BEEPER 7
// function control word bits
`define SPP_FC_EXT_RESET 0
`define SPP_FC_CLK_OUT 1
`define SPP_FC_PB2_PWM 2
`define SPP_FC_EDGE_FALL 3
`define SPP_FC_TA_CLK 4
`define SPP_FC_TA_LOW 5
`define SPP_FC_TB_CLK 6
// event status bits
`define SPP_EV_CHANGE 0
`define SPP_EV_EXT 1
// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define SPP_NPINS 6
`define SPP_RST_DIR 6'h3F
`define SPP_RST_BYTE 8'h00
`endif

// file: spp_pkg.sv
// types shared by the six pin port
package spp_pkg;
  // pad width
  typedef logic [5:0] spp_pins_t;
  // operating modes
  typedef enum logic [1:0]
  {
    SPP_MODE_NORMAL = 2'b00,
    SPP_MODE_HALT = 2'b01,
    SPP_MODE_STANDBY = 2'b10
  } spp_mode_e;
endpackage

// file: spp_port_sva.sv
// checker of the six pin port outputs, bound to the port
module spp_port_sva
(
  // clock, reset and register port
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pads and event outputs
  input wire logic [5:0] pad_in,
  input wire logic [5:0] pull_low_en,
  input wire logic ext_count_clock_in_a,
  input wire logic ext_count_clock_in_b,
  input wire logic ext_irq_signal,
  input wire logic ext_reset_req,
  input wire logic port_irq_req,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic prev_ff; // pin 0 level one cycle back
  logic [2:0] age_ff; // cycles since pin 0 last changed, saturating
  // age of the last pin 0 change, bounds the external irq delay
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_ff <= 1'b0;
      age_ff <= 3'h7;
    end
    else
    begin
      prev_ff <= pad_in[0];
      age_ff <= (prev_ff != pad_in[0]) ? 3'h0 : age_ff + {2'h0, age_ff != 3'h7};
    end
  end
  // register write that clears the bits of m at address a
  sequence s_clr(logic [7:0] a, logic [7:0] m);
    reg_wr && reg_addr == a && (reg_wdata & m) == 8'h00;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_pull_low_top: assert property (pull_low_en[5:4] == 2'b00)
    else $error("pull low enabled on pin 4 or 5");
  a_ext_pulse_one: assert property (ext_irq_signal |=> !ext_irq_signal)
    else $error("external irq pulse longer than one cycle");
  a_ext_after_edge: assert property (ext_irq_signal |-> age_ff < 3'h6)
    else $error("external irq without a recent pin 0 change");
  a_count_a_src: assert property (ext_count_clock_in_a |->
    $past(pad_in[2]) || $past(pad_in[2], 2) || $past(pad_in[2], 3))
    else $error("timer a clock high while pin 2 low");
  a_count_b_src: assert property (ext_count_clock_in_b |->
    $past(pad_in[2]) || $past(pad_in[2], 2) || $past(pad_in[2], 3))
    else $error("timer b clock high while pin 2 low");
  a_reset_pin_low: assert property (ext_reset_req |->
    !$past(pad_in[3]) || !$past(pad_in[3], 2) || !$past(pad_in[3], 3))
    else $error("reset request while pin 3 high");
  a_irq_en_off: assert property (s_clr(8'h1C, 8'h02) |=> ##2 !port_irq_req)
    else $error("port irq stays with its enable cleared");
  a_global_off: assert property (s_clr(8'h20, 8'h80) |=> ##2 !port_irq_req)
    else $error("port irq stays with global enable cleared");
  a_mask_all_off: assert property (s_clr(8'h38, 8'h03) |=> ##2 !irq)
    else $error("irq stays with every event masked");
endmodule
bind spp_port spp_port_sva i_sva (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pad_in(pad_in), .pull_low_en(pull_low_en), .ext_count_clock_in_a(ext_count_clock_in_a),
  .ext_count_clock_in_b(ext_count_clock_in_b), .ext_irq_signal(ext_irq_signal),
  .ext_reset_req(ext_reset_req), .port_irq_req(port_irq_req), .irq(irq));

// file: spp_board.sv
// board circuitry on the six pads: drivers, pull resistors, open pins
module spp_board
(
  // clock
  input wire logic clk,
  // device side of the pads
  input wire logic [5:0] pad_out,
  input wire logic [5:0] pad_oe,
  input wire logic [5:0] pull_high_en,
  input wire logic [5:0] pull_low_en,
  // external drivers on the board
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  output logic [5:0] pad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] last_ff = 6'h00; // last level, so an open pin never holds still
  always @(posedge clk)
    last_ff <= pad_in;
  // device drive, board drive, pulls, else a toggling open pin
  always_comb
    for (int i = 0; i < 6; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
        pull_high_en[i] ? 1'b1 : pull_low_en[i] ? 1'b0 : ~last_ff[i];
endmodule

// file: test_six_pin_port_with_wakeup.sv
// self-checking bench of the six pin port
module test_six_pin_port_with_wakeup;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, v;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [5:0] pad_in, pad_out, pad_oe, phe, ple;
  logic ir_car = 1'b0, pul = 1'b0, bep = 1'b0, ick = 1'b0;
  logic [1:0] op_mode = 2'b00;
  logic [5:0] ext_en = 6'h3F, ext_val = 6'h00;
  logic cnt_a, cnt_b, ext_int, rst_req, pirq, irq;
  int n_mismatch = 0, total_checks = 0, n_ext = 0, cyc = 0, base;
  logic [7:0] exp_q[$]; // expected read answers, oldest first
  always #2.5 clk = ~clk;
  spp_port i_dut
  (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pull_high_en(phe), .pull_low_en(ple), .ir_carrier_data(ir_car),
    .pulse_data(pul), .beeper_data(bep), .inst_clk_level(ick), .op_mode(op_mode),
    .ext_count_clock_in_a(cnt_a), .ext_count_clock_in_b(cnt_b), .ext_irq_signal(ext_int),
    .ext_reset_req(rst_req), .port_irq_req(pirq), .irq(irq)
  );
  spp_board i_board
  (
    .clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_high_en(phe),
    .pull_low_en(ple), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
  );
  // closing report and verdict
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // compare one value and count it
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus cycle; both strobes set each time so none is assigned twice
  task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  // idle cycles, ending just past an edge so outputs have settled
  task automatic idle(int n);
    bus(1'b0, 1'b0, reg_addr, 8'h00);
    repeat (n - 1) @(posedge clk);
    #1;
  endtask
  // cycle count, timeout and external pulse count
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    cyc <= cyc + 1;
    n_ext <= n_ext + int'(ext_int === 1'b1);
    if (cyc == 4000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  // result side: a read answer stands in the cycle after its strobe
  always @(negedge clk)
    if (rd_d)
      chk("reg_rdata", reg_rdata, exp_q.pop_front());
  initial
  begin
    void'($urandom(32'h5CDC2624));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, unmapped place
    rd(8'h04, 8'h3F);
    wr(8'h48, 8'hFF);
    rd(8'h48, 8'h00);
    // random latch data out, then open drain and read source
    v = {2'b00, 6'($urandom)};
    ext_val <= 6'($urandom);
    wr(8'h00, v);
    wr(8'h04, 8'h00);
    idle(3);
    chk("pad_oe", 8'(pad_oe), 8'h3F);
    chk("pad_out", 8'(pad_out), v);
    wr(8'h10, 8'h3F);
    wr(8'h2C, 8'h3F);
    idle(4);
    chk("pad_oe", 8'(pad_oe), ~v & 8'h3F);
    rd(8'h00, v);
    wr(8'h2C, 8'h00);
    rd(8'h00, v & {2'b00, ext_val});
    // pulls with the board drivers off
    ext_en <= 6'h00;
    wr(8'h04, 8'h3F);
    wr(8'h08, 8'h3F);
    idle(5);
    chk("pull_high_en", 8'(phe), 8'h3F);
    rd(8'h00, 8'h3F);
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'hFF);
    idle(3);
    chk("pull_low_en", 8'(ple), 8'h0F);
    // level change flag, enables and clearing
    ext_en <= 6'h3F;
    ext_val <= 6'h00;
    wr(8'h0C, 8'h00);
    idle(5);
    wr(8'h14, 8'h3F);
    wr(8'h1C, 8'h02);
    wr(8'h20, 8'h80);
    wr(8'h38, 8'h01);
    rd(8'h18, 8'h00);
    ext_val <= 6'h08;
    idle(6);
    chk("port_irq_req", 8'(pirq), 8'h01);
    chk("irq", 8'(irq), 8'h01);
    rd(8'h18, 8'h02);
    rd(8'h34, 8'h01);
    wr(8'h18, 8'h02);
    idle(3);
    chk("irq", 8'(irq), 8'h00);
    chk("port_irq_req", 8'(pirq), 8'h01);
    wr(8'h20, 8'h00);
    idle(3);
    chk("port_irq_req", 8'(pirq), 8'h00);
    wr(8'h20, 8'h80);
    wr(8'h18, 8'h00);
    idle(3);
    chk("port_irq_req", 8'(pirq), 8'h00);
    // external irq on pin 0, both edges, change detect off there
    wr(8'h24, 8'h40);
    wr(8'h38, 8'h02);
    for (int e = 0; e < 2; e++)
    begin
      wr(8'h30, 8'(e * 8));
      idle(4);
      base = n_ext;
      ext_val <= 6'h09;
      idle(6);
      chk("ext_irq_signal", 8'(n_ext - base), 8'(e == 0));
      ext_val <= 6'h08;
      idle(6);
      chk("ext_irq_signal", 8'(n_ext - base), 8'h01);
    end
    chk("irq", 8'(irq), 8'h01);
    rd(8'h18, 8'h00);
    rd(8'h34, 8'h02);
    ext_val <= 6'h0A;
    idle(5);
    rd(8'h18, 8'h02);
    wr(8'h24, 8'h00);
    // carrier on pin 1 for every polarity, data and carrier level
    wr(8'h04, 8'h3F);
    wr(8'h10, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      ir_car <= k[0];
      wr(8'h00, {6'h00, k[1], 1'b0});
      wr(8'h28, {5'h00, k[2], 2'b01});
      idle(3);
      chk("pad_oe1", 8'(pad_oe[1]), 8'h01);
      chk("pad_out1", 8'(pad_out[1]), 8'(k[0] & (k[1] ^ k[2])));
    end
    wr(8'h28, 8'h00);
    // pulse out, clock out, reset pin, timer clocks
    pul <= 1'b1;
    ick <= 1'b1;
    ext_val <= 6'h04;
    wr(8'h3C, 8'h80);
    wr(8'h30, 8'h57);
    idle(4);
    chk("ext_reset_req", 8'(rst_req), 8'h01);
    chk("pad4", 8'({pad_oe[4], pad_out[4]}), 8'h03);
    chk("pad2", 8'({pad_oe[2], pad_out[2]}), 8'h03);
    chk("count_clocks", 8'({cnt_a, cnt_b}), 8'h03);
    // beeper out, standby clock, low clock select, pin 3 released
    pul <= 1'b0;
    bep <= 1'b1;
    ick <= 1'b0;
    op_mode <= 2'b10;
    ext_val <= 6'h08;
    wr(8'h3C, 8'h00);
    wr(8'h40, 8'h80);
    wr(8'h30, 8'h33);
    idle(4);
    chk("ext_reset_req", 8'(rst_req), 8'h00);
    chk("pad4", 8'({pad_oe[4], pad_out[4]}), 8'h02);
    chk("pad2", 8'({pad_oe[2], pad_out[2]}), 8'h03);
    chk("count_clocks", 8'({cnt_a, cnt_b}), 8'h00);
    op_mode <= 2'b01;
    idle(4);
    chk("pad_oe4", 8'(pad_oe[4]), 8'h00);
    wr(8'h1C, 8'h00);
    wr(8'h38, 8'h00);
    idle(4);
    final_report();
  end
endmodule
